// File: design/mct_timer.sv
// Purpose: configurable timer/counter with APB registers
// Assumes: all inputs synchronous to pclk
// Notes: parameters select the wide, narrow, reduced, basic or advanced variant
//
// The register offsets and the APB slave port are this design's own decisions.
`default_nettype none
module mct_timer #(
    parameter int CNT_W = 32,
    parameter int N_CH = 4,
    parameter bit HAS_DIR = 1'b1,
    parameter bit HAS_CMPL = 1'b0,
    parameter bit HAS_ENC = 1'b1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // channels
    input wire logic [mct_pkg::MAX_CH-1:0] ch_in,
    output logic [mct_pkg::MAX_CH-1:0] ch_out,
    output logic [mct_pkg::N_PAIR-1:0] ch_out_n,
    // encoder and hall sensors
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic [2:0] hall_in,
    // inter-timer link and debug
    input wire logic trig_in,
    output logic trig_out,
    input wire logic dbg_halt,
    // interrupt
    output logic irq
);
    import mct_pkg::*;

    typedef struct packed {
        logic [CTL_W-1:0] ctrl;
        logic [PSC_W-1:0] psc;
        logic [PSC_W-1:0] psc_cnt;
        logic [CNT_W-1:0] arr;
        logic [CNT_W-1:0] cnt;
        logic down;
        logic [STS_W-1:0] sts;
        logic [STS_W-1:0] imask;
        logic [MAX_CH*CHF_W-1:0] chcfg;
        logic [DT_W-1:0] dtr;
        logic [MAX_CH-1:0][CNT_W-1:0] ccr;
        logic [MAX_CH-1:0] ref_lvl;
        logic [MAX_CH-1:0] in_prev;
        logic [1:0] enc_prev;
        logic [2:0] hall_prev;
        logic [31:0] prdata;
        logic trig;
    } mct_st_t;

    mct_st_t s_r;
    mct_st_t s_nxt;

    function automatic logic [CNT_W-1:0] fit(input logic [31:0] v);
        return v[CNT_W-1:0];
    endfunction

    function automatic logic [31:0] wide(input logic [CNT_W-1:0] v);
        return 32'(v);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= OFS_EGR);
    endfunction

    logic frozen;
    logic run;
    logic tick;
    logic going_up;
    logic upd;
    logic enc_step;
    logic enc_up;
    logic wr;
    logic rd_setup;
    logic [1:0] dir_mode;
    logic [1:0] chm;
    logic edge_seen;
    logic match;
    logic [STS_W-1:0] evt;
    logic [STS_W-1:0] w1c;
    logic [MAX_CH-1:0] ch_oe;
    logic out_block;
    logic [N_PAIR-1:0] pair_hi;
    logic [N_PAIR-1:0] pair_lo;

    assign wr = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign frozen = dbg_halt & s_r.ctrl[CTL_DBG];
    assign run = s_r.ctrl[CTL_EN] & ~frozen;
    // variants without HAS_DIR may only count up outside encoder mode
    assign dir_mode = HAS_DIR ? s_r.ctrl[CTL_DIR +: 2] : DIR_UP;
    // x4 quadrature decode: any edge of either phase is one count
    assign enc_step = HAS_ENC & s_r.ctrl[CTL_ENC] &
        ((enc_a ^ s_r.enc_prev[0]) | (enc_b ^ s_r.enc_prev[1]));
    assign enc_up = enc_a ^ s_r.enc_prev[1];

    always_comb begin
        s_nxt = s_r;
        tick = 1'b0;
        going_up = 1'b1;
        upd = 1'b0;
        evt = '0;
        w1c = '0;
        chm = CHM_CAPTURE;
        edge_seen = 1'b0;
        match = 1'b0;

        // prescaler: divide by psc + 1; a lowered psc must not stall the divider
        if (run && !s_r.ctrl[CTL_ENC]) begin
            if (s_r.psc_cnt >= s_r.psc) begin
                s_nxt.psc_cnt = '0;
                tick = 1'b1;
            end else begin
                s_nxt.psc_cnt = s_r.psc_cnt + 1'b1;
            end
        end else if (run) begin
            tick = enc_step;
        end

        if (s_r.ctrl[CTL_ENC]) begin
            going_up = enc_up;
        end else if (dir_mode == DIR_DOWN) begin
            going_up = 1'b0;
        end else if (dir_mode == DIR_CENTER) begin
            going_up = ~s_r.down;
        end

        if (tick) begin
            if (going_up) begin
                if (s_r.cnt >= s_r.arr) begin
                    upd = 1'b1;
                    if (dir_mode == DIR_CENTER && !s_r.ctrl[CTL_ENC]) begin
                        s_nxt.down = 1'b1;
                        s_nxt.cnt = s_r.arr - 1'b1;
                    end else begin
                        s_nxt.cnt = '0;
                    end
                end else begin
                    s_nxt.cnt = s_r.cnt + 1'b1;
                end
            end else begin
                if (s_r.cnt == '0) begin
                    upd = 1'b1;
                    if (dir_mode == DIR_CENTER && !s_r.ctrl[CTL_ENC]) begin
                        s_nxt.down = 1'b0;
                        s_nxt.cnt = fit(32'h1);
                    end else begin
                        s_nxt.cnt = s_r.arr;
                    end
                end else begin
                    s_nxt.cnt = s_r.cnt - 1'b1;
                end
            end
        end

        // one-pulse: stop at the end of the period
        if (upd && s_r.ctrl[CTL_OPM]) begin
            s_nxt.ctrl[CTL_EN] = 1'b0;
        end
        evt[STS_UPD] = upd;

        // a link pulse starts the counter from zero
        if (trig_in && s_r.ctrl[CTL_LINK]) begin
            s_nxt.ctrl[CTL_EN] = 1'b1;
            s_nxt.cnt = '0;
            s_nxt.psc_cnt = '0;
            s_nxt.down = 1'b0;
            evt[STS_TRIG] = 1'b1;
        end

        // channels from index N_CH upward do not exist in this variant
        for (int i = 0; i < MAX_CH; i++) begin
            if (i < N_CH) begin
                chm = s_r.chcfg[i*CHF_W +: 2];
                edge_seen = s_r.chcfg[i*CHF_W+CHF_POL] ?
                    (s_r.in_prev[i] & ~ch_in[i]) : (~s_r.in_prev[i] & ch_in[i]);
                match = tick && (s_r.cnt == s_r.ccr[i]);
                case (chm)
                    CHM_CAPTURE: begin
                        if (edge_seen) begin
                            s_nxt.ccr[i] = s_r.cnt;
                            evt[STS_CC0+i] = 1'b1;
                        end
                    end
                    CHM_TOGGLE: begin
                        if (match) begin
                            s_nxt.ref_lvl[i] = ~s_r.ref_lvl[i];
                            evt[STS_CC0+i] = 1'b1;
                        end
                    end
                    // ccr 0 gives always off, ccr above arr always on
                    CHM_PWM: begin
                        s_nxt.ref_lvl[i] = s_r.cnt < s_r.ccr[i];
                        evt[STS_CC0+i] = match;
                    end
                    CHM_PWM_INV: begin
                        s_nxt.ref_lvl[i] = ~(s_r.cnt < s_r.ccr[i]);
                        evt[STS_CC0+i] = match;
                    end
                    default: begin
                        s_nxt.ref_lvl[i] = 1'b0;
                    end
                endcase
                s_nxt.in_prev[i] = ch_in[i];
            end else begin
                s_nxt.ref_lvl[i] = 1'b0;
                s_nxt.in_prev[i] = 1'b0;
            end
        end

        // hall change latches the counter into channel 0
        if (HAS_ENC && s_r.ctrl[CTL_HALL] && hall_in != s_r.hall_prev) begin
            s_nxt.ccr[0] = s_r.cnt;
            evt[STS_HALL] = 1'b1;
        end
        s_nxt.hall_prev = hall_in;
        s_nxt.enc_prev = {enc_b, enc_a};
        s_nxt.trig = upd;

        // register writes win over counting
        if (wr) begin
            case (paddr)
                OFS_CTRL: s_nxt.ctrl = pwdata[CTL_W-1:0];
                OFS_PSC: s_nxt.psc = pwdata[PSC_W-1:0];
                OFS_ARR: s_nxt.arr = fit(pwdata);
                OFS_CNT: s_nxt.cnt = fit(pwdata);
                OFS_STS: w1c = pwdata[STS_W-1:0];
                OFS_IMASK: s_nxt.imask = pwdata[STS_W-1:0];
                OFS_CHCFG: s_nxt.chcfg = pwdata[MAX_CH*CHF_W-1:0];
                OFS_DTR: s_nxt.dtr = pwdata[DT_W-1:0];
                OFS_EGR: begin
                    if (pwdata[EGR_UG]) begin
                        s_nxt.cnt = '0;
                        s_nxt.psc_cnt = '0;
                        s_nxt.down = 1'b0;
                    end
                end
                default: begin
                    if (paddr >= OFS_CCR0 && paddr <= OFS_CCR3) begin
                        s_nxt.ccr[paddr[3:2]] = fit(pwdata);
                    end
                end
            endcase
        end
        // a new event in the clearing cycle stays set
        s_nxt.sts = (s_r.sts & ~w1c) | evt;

        // read data is loaded in the setup cycle
        if (rd_setup) begin
            case (paddr)
                OFS_CTRL: s_nxt.prdata = 32'(s_r.ctrl);
                OFS_PSC: s_nxt.prdata = 32'(s_r.psc);
                OFS_ARR: s_nxt.prdata = wide(s_r.arr);
                OFS_CNT: s_nxt.prdata = wide(s_r.cnt);
                OFS_STS: s_nxt.prdata = 32'(s_r.sts);
                OFS_IMASK: s_nxt.prdata = 32'(s_r.imask);
                OFS_CHCFG: s_nxt.prdata = 32'(s_r.chcfg);
                OFS_DTR: s_nxt.prdata = 32'(s_r.dtr);
                default: begin
                    if (paddr >= OFS_CCR0 && paddr <= OFS_CCR3) begin
                        s_nxt.prdata = wide(s_r.ccr[paddr[3:2]]);
                    end else begin
                        s_nxt.prdata = 32'h00000000;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.ctrl <= CTRL_RST;
            s_r.psc <= PSC_RST;
            s_r.arr <= ARR_RST[CNT_W-1:0];
        end else begin
            s_r <= s_nxt;
        end
    end

    // output stage
    assign out_block = HAS_CMPL & (frozen | ~s_r.ctrl[CTL_MOE]);

    generate
        for (genvar c = 0; c < MAX_CH; c++) begin : g_oe
            if (c < N_CH) begin : g_on
                assign ch_oe[c] = s_r.chcfg[c*CHF_W+CHF_OE];
            end else begin : g_off
                assign ch_oe[c] = 1'b0;
            end
        end
        for (genvar p = 0; p < N_PAIR; p++) begin : g_pair
            mct_dt_if dti ();
            assign dti.ref_lvl = s_r.ref_lvl[p];
            assign dti.en = ch_oe[p] & ~out_block;
            assign dti.dt = s_r.dtr;
            mct_deadtime u_dt (
                .pclk(pclk),
                .presetn(presetn),
                .p(dti.gen)
            );
            assign pair_hi[p] = dti.hi;
            assign pair_lo[p] = dti.lo;
        end
    endgenerate

    always_comb begin
        ch_out = s_r.ref_lvl & ch_oe;
        ch_out_n = '0;
        if (HAS_CMPL) begin
            ch_out[N_PAIR-1:0] = pair_hi;
            ch_out_n = pair_lo;
            ch_out[MAX_CH-1] = s_r.ref_lvl[MAX_CH-1] & ch_oe[MAX_CH-1] & ~out_block;
        end
    end

    assign trig_out = s_r.trig;
    assign irq = |(s_r.sts & s_r.imask);
    assign prdata = s_r.prdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped(paddr);
endmodule
`default_nettype wire

// File: inc/mct_pkg.sv
// Purpose: constants shared by the multi channel timer
// Assumes: APB with 32-bit data, byte addresses
// Notes: register map, field positions and reset values
`default_nettype none
package mct_pkg;
    localparam int MAX_CH = 4;
    localparam int N_PAIR = 3;
    localparam int DT_W = 8;
    localparam int PSC_W = 16;
    localparam int STS_W = 7;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PSC = 8'h04;
    localparam logic [7:0] OFS_ARR = 8'h08;
    localparam logic [7:0] OFS_CNT = 8'h0c;
    localparam logic [7:0] OFS_STS = 8'h10;
    localparam logic [7:0] OFS_IMASK = 8'h14;
    localparam logic [7:0] OFS_CHCFG = 8'h18;
    localparam logic [7:0] OFS_DTR = 8'h1c;
    localparam logic [7:0] OFS_CCR0 = 8'h20;
    localparam logic [7:0] OFS_CCR3 = 8'h2c;
    localparam logic [7:0] OFS_EGR = 8'h30;
    // control fields
    localparam int CTL_W = 9;
    localparam int CTL_EN = 0;
    localparam int CTL_DIR = 1;
    localparam int CTL_OPM = 3;
    localparam int CTL_DBG = 4;
    localparam int CTL_MOE = 5;
    localparam int CTL_LINK = 6;
    localparam int CTL_ENC = 7;
    localparam int CTL_HALL = 8;
    localparam logic [1:0] DIR_UP = 2'h0;
    localparam logic [1:0] DIR_DOWN = 2'h1;
    localparam logic [1:0] DIR_CENTER = 2'h2;
    // channel config: 4 bits per channel
    localparam int CHF_W = 4;
    localparam int CHF_POL = 2;
    localparam int CHF_OE = 3;
    localparam logic [1:0] CHM_CAPTURE = 2'h0;
    localparam logic [1:0] CHM_TOGGLE = 2'h1;
    localparam logic [1:0] CHM_PWM = 2'h2;
    localparam logic [1:0] CHM_PWM_INV = 2'h3;
    // status bits
    localparam int STS_UPD = 0;
    localparam int STS_CC0 = 1;
    localparam int STS_TRIG = 5;
    localparam int STS_HALL = 6;
    localparam int EGR_UG = 0;
    // reset values
    localparam logic [CTL_W-1:0] CTRL_RST = 9'h000;
    localparam logic [PSC_W-1:0] PSC_RST = 16'h0000;
    localparam logic [31:0] ARR_RST = 32'hffffffff;
endpackage
`default_nettype wire

// File: inc/mct_dt_if.sv
// Purpose: carries one complementary pair between timer core and dead-time stage
// Assumes: single clock domain
// Notes: src side is the timer core, gen side the dead-time stage
`default_nettype none
interface mct_dt_if;
    import mct_pkg::*;
    logic ref_lvl;
    logic en;
    logic [DT_W-1:0] dt;
    logic hi;
    logic lo;
    modport src (output ref_lvl, output en, output dt, input hi, input lo);
    modport gen (input ref_lvl, input en, input dt, output hi, output lo);
endinterface
`default_nettype wire

// File: design/mct_deadtime.sv
// Purpose: dead-time insertion for one complementary output pair
// Assumes: dt counts pclk cycles
// Notes: a reference edge during a gap restarts the gap
`default_nettype none
module mct_deadtime (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pair
    mct_dt_if.gen p
);
    import mct_pkg::*;

    typedef struct packed {
        logic ref_q;
        logic [DT_W-1:0] cnt;
        logic hi;
        logic lo;
    } mct_dt_st_t;

    mct_dt_st_t s_r;
    mct_dt_st_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (!p.en) begin
            s_nxt.ref_q = p.ref_lvl;
            s_nxt.cnt = '0;
            s_nxt.hi = 1'b0;
            s_nxt.lo = 1'b0;
        end else if (p.ref_lvl != s_r.ref_q) begin
            // both sides off for the gap
            s_nxt.ref_q = p.ref_lvl;
            s_nxt.cnt = p.dt;
            s_nxt.hi = (p.dt == '0) & p.ref_lvl;
            s_nxt.lo = (p.dt == '0) & ~p.ref_lvl;
        end else if (s_r.cnt != '0) begin
            s_nxt.cnt = s_r.cnt - 1'b1;
            s_nxt.hi = (s_r.cnt == 1) & s_r.ref_q;
            s_nxt.lo = (s_r.cnt == 1) & ~s_r.ref_q;
        end else begin
            s_nxt.hi = s_r.ref_q;
            s_nxt.lo = ~s_r.ref_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign p.hi = s_r.hi;
    assign p.lo = s_r.lo;
endmodule
`default_nettype wire

// File: sim/mct_timer_sva.sv
// Purpose: port checks for mct_timer
// Assumes: one clock domain, pclk
// Notes: bound to every mct_timer instance
`default_nettype none
module mct_timer_sva (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // outputs
    input wire logic [mct_pkg::MAX_CH-1:0] ch_out,
    input wire logic [mct_pkg::N_PAIR-1:0] ch_out_n,
    input wire logic trig_out,
    input wire logic irq
);
    import mct_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    assign acc = psel && penable;
    chk_ready_high: assert property (pready)
        else $error("pready low");
    chk_err_place: assert property (pslverr |-> acc)
        else $error("pslverr outside access");
    chk_err_align: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("unaligned access accepted");
    chk_err_range: assert property (acc && paddr > OFS_EGR |-> pslverr)
        else $error("address above map accepted");
    chk_ok_mapped: assert property (acc && paddr[1:0] == 2'h0 && paddr <= OFS_EGR |-> !pslverr)
        else $error("mapped access refused");
    chk_err_rdzero: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("refused read not zero");
    chk_egr_rdzero: assert property (acc && !pwrite && paddr == OFS_EGR |-> prdata == 32'h0)
        else $error("event register read not zero");
    chk_pair_apart: assert property ((ch_out[2:0] & ch_out_n) == 3'h0)
        else $error("both outputs of a pair active");
    cover property ($rose(trig_out));
    cover property ($rose(irq));
    cover property (acc && pslverr);
    cover property ($rose(ch_out_n[0]));
endmodule
bind mct_timer mct_timer_sva mct_timer_sva_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .ch_out, .ch_out_n, .trig_out, .irq);
`default_nettype wire

// File: sim/mct_field.sv
// Purpose: far side model: quadrature encoder and hall sensor lines
// Assumes: lines move just after a rising pclk edge
// Notes: gray order, so one phase changes per step
`default_nettype none
module mct_field (
    // clock
    input wire logic pclk,
    // sensor lines
    output logic enc_a,
    output logic enc_b,
    output logic [2:0] hall_in
);
    logic [1:0] ph_r = 2'h0;
    logic [2:0] hall_r = 3'h1;
    assign enc_a = ph_r[0] ^ ph_r[1];
    assign enc_b = ph_r[1];
    assign hall_in = hall_r;
    // one encoder edge, then a quiet gap, short or long
    task automatic step(input logic fwd, input int quiet);
        @(posedge pclk);
        ph_r <= fwd ? ph_r + 2'h1 : ph_r - 2'h1;
        repeat (quiet) @(posedge pclk);
    endtask
    task automatic hall_next();
        @(posedge pclk);
        hall_r <= {hall_r[1:0], hall_r[2]};
        repeat (3) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// File: sim/testbench.sv
// Purpose: self-checking bench for mct_timer, advanced variant
// Assumes: apb master on pclk
// Notes: field model drives encoder and hall lines
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import mct_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, trig_in = 1'b0, dbg_halt = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rv, prdata_d, rv_d;
    logic pready, pslverr, er, trig_out, irq, enc_a, enc_b;
    logic [3:0] ch_in = 4'h0, ch_out;
    logic [2:0] ch_out_n, hall_in;
    int bad_count = 0, comparisons = 0;
    always #5 pclk = ~pclk;
    mct_timer #(.CNT_W(16), .HAS_CMPL(1'b1)) mct_timer_i (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ch_in, .ch_out, .ch_out_n,
        .enc_a, .enc_b, .hall_in, .trig_in, .trig_out, .dbg_halt, .irq);
    // reduced dual-channel variant on the same bus, sees every write
    mct_timer #(.CNT_W(16), .N_CH(2), .HAS_DIR(1'b0), .HAS_ENC(1'b0)) mct_timer_dual_i (.pclk,
        .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata(prdata_d), .pready(),
        .pslverr(), .ch_in, .ch_out(), .ch_out_n(), .enc_a, .enc_b, .hall_in, .trig_in,
        .trig_out(), .dbg_halt, .irq());
    mct_field mct_field_i (.pclk, .enc_a, .enc_b, .hall_in);
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        if (bad_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata;
        rv_d = prdata_d;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // cycles between two update pulses
    task automatic gap(output int n);
        do @(posedge pclk); while (trig_out !== 1'b1);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (trig_out !== 1'b1);
    endtask
    task automatic t_reset();
        logic [7:0] odd [3] = '{8'h02, 8'h34, OFS_EGR};
        bus(1'b0, OFS_ARR, 32'h0);
        chk("arr reset", 32'h0000ffff, rv);
        bus(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, rv);
        for (int k = 0; k < 3; k++) begin
            bus(1'b0, odd[k], 32'h0);
            chk("odd addr err", {31'h0, k < 2}, {31'h0, er});
            chk("odd addr data", 32'h0, rv);
        end
    endtask
    task automatic t_count();
        logic [1:0] dirs [3] = '{DIR_UP, DIR_DOWN, DIR_CENTER};
        int pscs [3] = '{2, 0, 1};
        int arrs [3] = '{3, 5, 4};
        int n;
        for (int k = 0; k < 3; k++) begin
            bus(1'b1, OFS_CTRL, 32'h0);
            bus(1'b1, OFS_PSC, 32'(pscs[k]));
            bus(1'b1, OFS_ARR, 32'(arrs[k]));
            bus(1'b1, OFS_CNT, 32'h0);
            bus(1'b1, OFS_CTRL, {29'h0, dirs[k], 1'b1});
            gap(n);
            gap(n);
            chk("update period", 32'((pscs[k] + 1) * (k == 2 ? arrs[k] : arrs[k] + 1)), n);
        end
    endtask
    // both timers see the same writes; only the full one may count down
    task automatic t_updown();
        bus(1'b1, OFS_CTRL, 32'h0);
        bus(1'b1, OFS_PSC, 32'h0);
        bus(1'b1, OFS_ARR, 32'hffff);
        bus(1'b1, OFS_CNT, 32'h10);
        bus(1'b1, OFS_CTRL, 32'h3);
        bus(1'b1, OFS_CTRL, 32'h0);
        bus(1'b0, OFS_CNT, 32'h0);
        chk("down count", 32'hd, rv);
        chk("reduced up only", 32'h13, rv_d);
    endtask
    task automatic t_irq();
        int n;
        bus(1'b1, OFS_STS, 32'h7f);
        bus(1'b1, OFS_CTRL, 32'h1);
        gap(n);
        bus(1'b1, OFS_CTRL, 32'h0);
        bus(1'b0, OFS_STS, 32'h0);
        chk("update flag", 32'h1, {31'h0, rv[STS_UPD]});
        chk("irq masked", 32'h0, {31'h0, irq});
        bus(1'b1, OFS_IMASK, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq raised", 32'h1, {31'h0, irq});
        bus(1'b1, OFS_STS, 32'h1);
        bus(1'b0, OFS_STS, 32'h0);
        chk("flag cleared", 32'h0, {31'h0, rv[STS_UPD]});
        chk("irq cleared", 32'h0, {31'h0, irq});
    endtask
    // high counts of a pair over one steady period
    task automatic win(input int len, input int ccr, input int ehi, input int elo);
        int hi = 0, lo = 0;
        bus(1'b1, OFS_CCR0, 32'(ccr));
        repeat (40) @(posedge pclk);
        repeat (len) begin
            @(posedge pclk);
            hi += int'(ch_out[0] === 1'b1);
            lo += int'(ch_out_n[0] === 1'b1);
        end
        chk("hi time", 32'(ehi), 32'(hi));
        chk("lo time", 32'(elo), 32'(lo));
    endtask
    task automatic t_pwm();
        bus(1'b1, OFS_PSC, 32'h0);
        bus(1'b1, OFS_ARR, 32'h9);
        bus(1'b1, OFS_DTR, 32'h2);
        bus(1'b1, OFS_CHCFG, 32'ha);
        bus(1'b1, OFS_CTRL, 32'h21);
        win(10, 0, 0, 10);
        win(10, 10, 10, 0);
        win(10, 4, 2, 4);
        bus(1'b1, OFS_CHCFG, 32'h9);
        win(20, 4, 8, 8);
        bus(1'b1, OFS_CHCFG, 32'ha);
        bus(1'b1, OFS_CTRL, 32'h25);
        win(18, 4, 5, 9);
        bus(1'b1, OFS_CTRL, 32'h31);
        dbg_halt <= 1'b1;
        bus(1'b1, OFS_CNT, 32'h3);
        repeat (20) @(posedge pclk);
        chk("halted pair", 32'h0, {30'h0, ch_out[0], ch_out_n[0]});
        bus(1'b0, OFS_CNT, 32'h0);
        chk("frozen count", 32'h3, rv);
        dbg_halt <= 1'b0;
    endtask
    task automatic t_link();
        bus(1'b1, OFS_CTRL, 32'h48);
        bus(1'b1, OFS_STS, 32'h7f);
        trig_in <= 1'b1;
        @(posedge pclk);
        trig_in <= 1'b0;
        bus(1'b0, OFS_CTRL, 32'h0);
        chk("link start", 32'h49, rv);
        bus(1'b0, OFS_STS, 32'h0);
        chk("link flag", 32'h1, {31'h0, rv[STS_TRIG]});
        repeat (12) @(posedge pclk);
        bus(1'b0, OFS_CTRL, 32'h0);
        chk("one pulse stop", 32'h48, rv);
    endtask
    task automatic t_enc();
        bus(1'b1, OFS_CTRL, 32'h0);
        bus(1'b1, OFS_ARR, 32'hffff);
        bus(1'b1, OFS_CNT, 32'h0);
        bus(1'b1, OFS_CTRL, 32'h81);
        repeat (4) mct_field_i.step(1'b1, 2);
        bus(1'b0, OFS_CNT, 32'h0);
        chk("encoder fwd", 32'h4, rv);
        repeat (2) mct_field_i.step(1'b0, 6);
        bus(1'b0, OFS_CNT, 32'h0);
        chk("encoder back", 32'h2, rv);
        bus(1'b1, OFS_EGR, 32'h1);
        bus(1'b0, OFS_CNT, 32'h0);
        chk("restart", 32'h0, rv);
        bus(1'b1, OFS_CTRL, 32'h101);
        bus(1'b1, OFS_STS, 32'h7f);
        mct_field_i.hall_next();
        bus(1'b0, OFS_STS, 32'h0);
        chk("hall flag", 32'h1, {31'h0, rv[STS_HALL]});
    endtask
    task automatic t_capture();
        bus(1'b1, OFS_CTRL, 32'h1);
        for (int p = 0; p < 2; p++) begin
            bus(1'b1, OFS_CHCFG, p ? 32'h4444 : 32'h0);
            for (int i = 0; i < 4; i++) begin
                bus(1'b1, OFS_STS, 32'h7f);
                ch_in[i] <= !p;
                repeat (3) @(posedge pclk);
                bus(1'b0, OFS_STS, 32'h0);
                chk("capture flags", 32'h1 << i, {28'h0, rv[4:1]});
                chk("dual capture", i < 2 ? 32'h1 << i : 32'h0, {28'h0, rv_d[4:1]});
            end
        end
    endtask
    initial begin
        #100us;
        bad_count++;
        conclude();
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_count();
        t_irq();
        t_updown();
        t_pwm();
        t_link();
        t_enc();
        t_capture();
        conclude();
    end
endmodule
`default_nettype wire
